// [sadc_analog_model.sv]
/*
  Far-side model: comparator in front of the capacitor array.
  Assumes the trial code settles within one converter clock period.
*/
`timescale 1ns/1ps
module sadc_analog_model (
  input wire logic pclk,
  input wire sadc_pkg::sadc_analog_type analog,
  input wire logic [9:0] level,
  output logic comp_high
);
  import sadc_pkg::*;
  // ****************************************
  // Comparator
  // ****************************************
  logic junk_r = 1'h0;
  always @(posedge pclk)
  begin
    junk_r <= ~junk_r;
  end
  // Off or sampling: no defined answer, so the line wanders rather than hold
  assign comp_high = (analog.powered && !analog.hold_connect) ? (level >= analog.trial) : junk_r;
endmodule // sadc_analog_model

// [sadc_pkg.sv]
/*
  Package for the converter sequencer: register offsets, field positions,
  reset values, timing counts, state encoding and the analog-side carrier.
  Assumes a 200 MHz APB clock and one instruction cycle of four clocks.
*/
package sadc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_REFSEL = 8'h04;
  localparam logic [7:0] OFS_TIMING = 8'h08;
  localparam logic [7:0] OFS_RES_HI = 8'h0C;
  localparam logic [7:0] OFS_RES_LO = 8'h10;
  localparam logic [7:0] OFS_FLAG = 8'h14;
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_REFSEL = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'h00;
  localparam logic [7:0] MASK_CTRL0 = 8'h3D;
  localparam logic [7:0] MASK_REFSEL = 8'h0F;
  localparam logic [7:0] MASK_TIMING = 8'hBF;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EN_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHS_LSB = 2;
  localparam int PREF_LSB = 2;
  localparam int NREF_LSB = 0;
  localparam int FMT_BIT = 7;
  localparam int ACQ_LSB = 3;
  localparam int CLKSEL_LSB = 0;
  localparam logic [3:0] CHS_FIRST = 4'h3;
  localparam logic [3:0] CHS_LAST = 4'hB;
  localparam logic [3:0] CHS_DAC = 4'hE;
  localparam logic [3:0] CHS_FVR = 4'hF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 200_000_000;
  localparam int FRC_HZ = 600_000;
  localparam logic [8:0] FRC_CYC = 9'(CLK_HZ / FRC_HZ);
  localparam logic [2:0] INSTR_CYC = 3'h4;
  localparam logic [4:0] CONV_TAD = 5'h0B;
  localparam logic [4:0] DISCH_TAD = 5'h02;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FRCDLY = 3'b001,
    ST_ACQ = 3'b010,
    ST_CONV = 3'b011,
    ST_DISCH = 3'b100
  } sadc_state_type;

  typedef struct packed {
    logic powered;
    logic [3:0] chan;
    logic chan_valid;
    logic [1:0] pref;
    logic [1:0] nref;
    logic hold_connect;
    logic [9:0] trial;
  } sadc_analog_type;

  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h0: acq_tads = 5'h00;
      3'h1: acq_tads = 5'h02;
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0C;
      3'h6: acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction

  function automatic logic [8:0] tad_cycles(input logic [2:0] code);
    case (code)
      3'h0: tad_cycles = 9'h002;
      3'h4: tad_cycles = 9'h004;
      3'h1: tad_cycles = 9'h008;
      3'h5: tad_cycles = 9'h010;
      3'h2: tad_cycles = 9'h020;
      3'h6: tad_cycles = 9'h040;
      default: tad_cycles = FRC_CYC;
    endcase
  endfunction

endpackage

// [sadc_sequencer.sv]
/*
  Successive-approximation converter sequencer with an APB register slave.
  Assumes the comparator answer is synchronous to pclk and settles within
  one converter clock period; the analog array, multiplexer and the
  compare unit that sends the trigger are outside.
*/
`timescale 1ns/1ps

// Summary of operation
// - Compare trigger sets the status bit and pulses a timer clear.
// - Channel field codes 3..11, 14 and 15 route to defined inputs.
// - Writing one to bit 1 starts; hardware clears it when done.
// - Status bit reads one from a start until completion or abort, also while a start waits out the discharge wait.
// - Enable bit clear stops and gates the whole converter.
// - Reserved channel codes connect nothing; result undefined.
// - Positive reference: 00 supply, 01 external pin, 10 fixed reference.
// - Negative reference: 00 ground, 01 external pin.
// - Format bit set gives right justified, clear left justified.
// - Acquisition codes give 0,2,4,6,8,12,16,20 converter clock periods.
// - Hold capacitor stays on the channel until conversion begins.
// - Clock field picks system divide 2..64 or the internal oscillator.
// - Internal oscillator runs at about 600 kHz, free of system clock; the code counts it as FRC_CYC pclk cycles.
// - With the internal oscillator, start waits one instruction cycle.
// - Unimplemented register bits read zero.
// - Completion clears status, sets the flag, loads result bytes.
// - A conversion takes 11 converter clock periods after acquisition.
// - Clearing status mid-conversion aborts and stores a filled partial.
// - Wait 2 converter clock periods before the next acquisition.
module sadc_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_trigger,
  input wire logic comp_high,
  output logic timer_clear,
  output logic conv_flag,
  output sadc_pkg::sadc_analog_type analog
);
  import sadc_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] ctrl0_r, ctrl0_nxt, refsel_r, refsel_nxt, timing_r, timing_nxt;
  logic go_r, go_nxt, flag_r, flag_nxt, tclr_r, tclr_nxt;
  logic [9:0] res_r, res_nxt, sar_r, sar_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  sadc_state_type state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [8:0] div_r, div_nxt;
  logic [3:0] cticks_r, cticks_nxt;
  sadc_analog_type ana_r, ana_nxt;
  logic wr, wr_ctrl0, go_set, go_clr, en, frc, tick, done_w, mapped;
  logic [7:0] res_hi, res_lo;
  logic [3:0] pos;

  assign en = ctrl0_r[EN_BIT];
  assign frc = timing_r[CLKSEL_LSB +: 2] == 2'b11;
  assign wr = psel && penable && pwrite;
  assign wr_ctrl0 = wr && paddr == OFS_CTRL0;
  assign go_set = en && ((wr_ctrl0 && pwdata[GO_BIT]) || special_trigger);
  assign go_clr = wr_ctrl0 && !pwdata[GO_BIT];
  assign mapped = paddr == OFS_CTRL0 || paddr == OFS_REFSEL || paddr == OFS_TIMING ||
                  paddr == OFS_RES_HI || paddr == OFS_RES_LO || paddr == OFS_FLAG;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = rdat_r;
  assign timer_clear = tclr_r;
  assign conv_flag = flag_r;
  assign analog = ana_r;

  // ****************************************
  // Result formatting
  // ****************************************
  always_comb
  begin
    if (timing_r[FMT_BIT])
    begin
      res_hi = {6'h00, res_r[9:8]};
      res_lo = res_r[7:0];
    end
    else
    begin
      res_hi = res_r[9:2];
      res_lo = {res_r[1:0], 6'h00};
    end
  end

  // ****************************************
  // APB registers
  // ****************************************
  always_comb
  begin
    ctrl0_nxt = ctrl0_r;
    refsel_nxt = refsel_r;
    timing_nxt = timing_r;
    flag_nxt = flag_r;
    rdat_nxt = rdat_r;
    tclr_nxt = special_trigger && en;
    if (wr && paddr == OFS_CTRL0)
      ctrl0_nxt = pwdata[7:0] & MASK_CTRL0;
    if (wr && paddr == OFS_REFSEL)
      refsel_nxt = pwdata[7:0] & MASK_REFSEL;
    if (wr && paddr == OFS_TIMING)
      timing_nxt = pwdata[7:0] & MASK_TIMING;
    if (wr && paddr == OFS_FLAG && pwdata[0])
      flag_nxt = 1'b0;
    if (done_w)
      flag_nxt = 1'b1;
    if (psel && !penable)
    begin
      rdat_nxt = 32'h0000_0000;
      case (paddr)
        OFS_CTRL0: rdat_nxt[7:0] = ctrl0_r | {6'h00, go_r, 1'b0};
        OFS_REFSEL: rdat_nxt[7:0] = refsel_r;
        OFS_TIMING: rdat_nxt[7:0] = timing_r;
        OFS_RES_HI: rdat_nxt[7:0] = res_hi;
        OFS_RES_LO: rdat_nxt[7:0] = res_lo;
        OFS_FLAG: rdat_nxt[0] = flag_r;
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0_r <= RST_CTRL0;
      refsel_r <= RST_REFSEL;
      timing_r <= RST_TIMING;
      flag_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
      tclr_r <= 1'b0;
    end
    else
    begin
      ctrl0_r <= ctrl0_nxt;
      refsel_r <= refsel_nxt;
      timing_r <= timing_nxt;
      flag_r <= flag_nxt;
      rdat_r <= rdat_nxt;
      tclr_r <= tclr_nxt;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Divider is held in reset while idle so a disabled converter toggles nothing
  assign tick = div_r == tad_cycles(timing_r[CLKSEL_LSB +: 3]) - 9'h001;
  assign pos = 4'(CONV_TAD - cnt_r[3:0] - 5'h01);
  assign done_w = state_r == ST_CONV && tick && cnt_r == CONV_TAD - 5'h01 && !go_clr;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sar_nxt = sar_r;
    res_nxt = res_r;
    go_nxt = go_r;
    div_nxt = (state_r == ST_IDLE || state_r == ST_FRCDLY || tick) ? 9'h000 : div_r + 9'h001;
    cticks_nxt = (state_r == ST_CONV && tick) ? cticks_r + 4'h1 : cticks_r;
    case (state_r)
      ST_IDLE:
      begin
        cticks_nxt = 4'h0;
        if (go_r && en)
        begin
          sar_nxt = 10'h000;
          if (frc)
          begin
            state_nxt = ST_FRCDLY;
            cnt_nxt = 5'(INSTR_CYC - 3'h1);
          end
          else if (acq_tads(timing_r[ACQ_LSB +: 3]) != 5'h00)
          begin
            state_nxt = ST_ACQ;
            cnt_nxt = acq_tads(timing_r[ACQ_LSB +: 3]);
          end
          else
          begin
            state_nxt = ST_CONV;
            cnt_nxt = 5'h00;
          end
        end
      end
      ST_FRCDLY:
      begin
        cnt_nxt = cnt_r - 5'h01;
        if (cnt_r == 5'h00)
        begin
          cnt_nxt = acq_tads(timing_r[ACQ_LSB +: 3]);
          state_nxt = (cnt_nxt == 5'h00) ? ST_CONV : ST_ACQ;
        end
      end
      ST_ACQ:
        if (tick)
        begin
          cnt_nxt = cnt_r - 5'h01;
          if (cnt_r == 5'h01)
          begin
            state_nxt = ST_CONV;
            cnt_nxt = 5'h00;
          end
        end
      ST_CONV:
        if (tick)
        begin
          // First period samples, the next ten resolve one bit each
          if (cnt_r != 5'h00)
            sar_nxt[pos] = comp_high;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == CONV_TAD - 5'h01)
          begin
            res_nxt = sar_nxt;
            go_nxt = 1'b0;
            state_nxt = ST_DISCH;
            cnt_nxt = DISCH_TAD;
          end
        end
      ST_DISCH:
        if (tick)
        begin
          cnt_nxt = cnt_r - 5'h01;
          if (cnt_r == 5'h01)
            state_nxt = ST_IDLE;
        end
      default:
        state_nxt = ST_IDLE;
    endcase
    // Abort keeps converted bits and copies the last one downward
    if (go_clr && state_r != ST_IDLE && state_r != ST_DISCH)
    begin
      state_nxt = ST_DISCH;
      cnt_nxt = DISCH_TAD;
      if (state_r == ST_CONV && cnt_r > 5'h01)
      begin
        res_nxt = sar_r;
        for (int i = 0; i < 10; i++)
          if (i < 11 - int'(cnt_r))
            res_nxt[i] = sar_r[11 - int'(cnt_r)];
      end
    end
    if (go_clr)
      go_nxt = 1'b0;
    if (go_set)
      go_nxt = 1'b1;
    if (!en)
    begin
      state_nxt = ST_IDLE;
      go_nxt = 1'b0;
    end
    ana_nxt.powered = en;
    ana_nxt.chan = ctrl0_r[CHS_LSB +: 4];
    ana_nxt.chan_valid = (ana_nxt.chan >= CHS_FIRST && ana_nxt.chan <= CHS_LAST) ||
                         ana_nxt.chan == CHS_DAC || ana_nxt.chan == CHS_FVR;
    ana_nxt.pref = refsel_r[PREF_LSB +: 2];
    ana_nxt.nref = refsel_r[NREF_LSB +: 2];
    ana_nxt.hold_connect = en && (state_r == ST_IDLE || state_r == ST_FRCDLY ||
                           state_r == ST_ACQ);
    ana_nxt.trial = sar_r;
    if (state_r == ST_CONV && cnt_r != 5'h00)
      ana_nxt.trial[pos] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 5'h00;
      sar_r <= 10'h000;
      res_r <= 10'h000;
      go_r <= 1'b0;
      div_r <= 9'h000;
      cticks_r <= 4'h0;
      ana_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sar_r <= sar_nxt;
      res_r <= res_nxt;
      go_r <= go_nxt;
      div_r <= div_nxt;
      cticks_r <= cticks_nxt;
      ana_r <= ana_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_trig_sets_go: assert property (special_trigger && en |=> go_r)
    else $error("trigger did not set status");
  chk_trig_timer: assert property (special_trigger && en |=> timer_clear ##1 !timer_clear
    || special_trigger)
    else $error("timer clear pulse wrong");
  chk_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_off_idle: assert property (!en |=> state_r == ST_IDLE && !go_r)
    else $error("disabled converter still busy");
  chk_done_flag: assert property (done_w |=> flag_r && res_r == $past(sar_nxt))
    else $error("completion did not set flag or result");
  chk_conv_len: assert property (done_w |-> cticks_r == 4'hA)
    else $error("conversion length wrong");
  chk_frc_delay: assert property ($rose(state_r == ST_FRCDLY) && en && !go_clr |->
    (state_r == ST_FRCDLY)[*4])
    else $error("oscillator start delay wrong");
  chk_hold_acq: assert property (state_r == ST_ACQ && en |=> analog.hold_connect)
    else $error("hold capacitor released during acquisition");
  chk_disch_hold: assert property (state_r == ST_DISCH && !tick && en |=> state_r == ST_DISCH)
    else $error("discharge wait cut short");

  cov_trigger_conv: cover property (special_trigger && en ##[1:1000] done_w);
  cov_abort: cover property (state_r == ST_CONV && go_clr);
  cov_frc_start: cover property (state_r == ST_FRCDLY ##1 state_r == ST_ACQ);

endmodule // sadc_sequencer

// [testbench.sv]
/*
  Self-checking bench for the converter sequencer and its comparator model.
  Assumes the APB slave answers with no wait states and a 200 MHz pclk.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  import sadc_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  localparam int OSC = 200_000_000 / 600_000;
  localparam int INSTR = 4;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, special_trigger = 1'h0, comp_high, timer_clear, conv_flag;
  sadc_analog_type analog;
  logic [9:0] level = 10'h000;
  logic [7:0] rd;
  logic [7:0] wmask[3] = '{8'h3D, 8'h0D, 8'hBD};
  logic [7:0] ofs[3] = '{OFS_CTRL0, OFS_REFSEL, OFS_TIMING};
  logic [2:0] last_ck = 3'h0, ck;
  logic last_err;
  int num_errors = 0, checks_done = 0, cyc = 0, t_done = 0;

  sadc_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .special_trigger(special_trigger), .comp_high(comp_high),
    .timer_clear(timer_clear), .conv_flag(conv_flag), .analog(analog));
  sadc_analog_model far_side (.pclk(pclk), .analog(analog), .level(level),
    .comp_high(comp_high));

  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  // Cut a hang short well above the longest planned run
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic int converter_clock_period(input logic [2:0] c);
    return (c[1:0] == 2'h3) ? OSC : 2 << {c[1:0], c[2]};
  endfunction
  function automatic int acq(input logic [2:0] c);
    return (c < 3'h5) ? 2 * c : 4 * c - 8;
  endfunction
  function automatic logic [15:0] fmt(input logic [9:0] v, input logic r);
    return r ? {6'h00, v} : {v, 6'h00};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    // No give-up count: a slave that never answers runs into the bench timeout
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    rd = prdata[7:0];
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Rush starts right after the last completion, inside the discharge wait
  task automatic convert(input logic [2:0] c, input logic [2:0] aq, input logic fm,
    input logic [3:0] ch, input logic trig, input logic rush);
    int t0, ex, pend;
    logic seen;
    logic [15:0] res;
    if (!rush)
    begin
      repeat (2 * converter_clock_period(last_ck)) @(posedge pclk);
    end
    apb(1'h1, OFS_TIMING, {fm, 1'h0, aq, c});
    apb(1'h1, OFS_CTRL0, {2'h0, ch, 2'h1});
    level <= 10'($urandom);
    if (trig)
    begin
      @(posedge pclk) special_trigger <= 1'h1;
      @(posedge pclk) special_trigger <= 1'h0;
      t0 = cyc;
      #1 seen = timer_clear;
      @(posedge pclk);
      #1 `CHK("timer clear", 1'h1, seen)
      `CHK("timer pulse", 1'h0, timer_clear)
    end
    else
    begin
      apb(1'h1, OFS_CTRL0, {2'h0, ch, 2'h3});
      t0 = cyc;
    end
    pend = rush ? 2 * converter_clock_period(c) - (t0 - t_done) : 0;
    ex = (acq(aq) + 11) * converter_clock_period(c) + ((c[1:0] == 2'h3) ? INSTR : 0) + ((pend > 0) ? pend : 0);
    apb(1'h0, OFS_CTRL0, 8'h00);
    if (!rush) `CHK("busy", 1'h1, rd[1])
    if (!rush && !trig && aq != 3'h0 && c[1:0] != 2'h3) #1 `CHK("hold", 1'h1, analog.hold_connect)
    while (rd[1] === 1'h1 && cyc - t0 < 8000)
    begin
      apb(1'h0, OFS_CTRL0, 8'h00);
    end
    t_done = cyc;
    last_ck = c;
    `CHK("ctrl after", {2'h0, ch, 2'h1}, rd)
    `CHK("time", 1'h1, 1'(cyc - t0 >= ex - 4 && cyc - t0 <= ex + 10))
    res = fmt(level, fm);
    apb(1'h0, OFS_RES_HI, 8'h00);
    `CHK("result high", res[15:8], rd)
    apb(1'h0, OFS_RES_LO, 8'h00);
    `CHK("result low", res[7:0], rd)
    `CHK("flag pin", 1'h1, conv_flag)
    apb(1'h1, OFS_FLAG, 8'h01);
    apb(1'h0, OFS_FLAG, 8'h00);
    `CHK("flag clear", 8'h00, rd)
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'hABCC));
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'h0, ofs[i], 8'h00);
      `CHK("reset value", 8'h00, rd)
      apb(1'h1, ofs[i], 8'hFD);
      apb(1'h0, ofs[i], 8'h00);
      `CHK("implemented bits", wmask[i], rd)
    end
    apb(1'h0, 8'h18, 8'h00);
    `CHK("unmapped error", 1'h1, last_err)
    `CHK("unmapped data", 8'h00, rd)
    `CHK("ready", 1'h1, pready)
    for (int i = 0; i < 16; i++)
    begin
      apb(1'h1, OFS_CTRL0, {2'h0, 4'(i), 2'h1});
      apb(1'h1, OFS_REFSEL, 8'(i));
      repeat (2) @(posedge pclk);
      #1 `CHK("channel", 4'(i), analog.chan)
      `CHK("channel valid", 1'((i > 2 && i < 12) || i > 13), analog.chan_valid)
      if (i % 4 < 2) `CHK("neg ref", 2'(i), analog.nref)
      if (i / 4 != 3) `CHK("pos ref", 2'(i / 4), analog.pref)
      `CHK("powered", 1'h1, analog.powered)
    end
    apb(1'h1, OFS_CTRL0, 8'h02);
    apb(1'h0, OFS_CTRL0, 8'h00);
    `CHK("start while off", 8'h00, rd)
    `CHK("off", 1'h0, analog.powered)
    @(posedge pclk) special_trigger <= 1'h1;
    @(posedge pclk) special_trigger <= 1'h0;
    #1 `CHK("trigger while off", 1'h0, timer_clear)
    convert(3'h0, 3'h0, 1'h0, 4'h3, 1'h0, 1'h0);
    convert(3'h6, 3'h7, 1'h1, 4'hB, 1'h1, 1'h0);
    convert(3'h6, 3'h0, 1'h0, 4'h7, 1'h0, 1'h1);
    convert(3'h3, 3'h0, 1'h1, 4'hF, 1'h0, 1'h0);
    convert(3'h7, 3'h1, 1'h0, 4'hE, 1'h0, 1'h0);
    repeat (6)
    begin
      ck = 3'($urandom);
      if (ck[1:0] == 2'h3) ck[0] = 1'h0;
      convert(ck, 3'($urandom), 1'($urandom), 4'(3 + $urandom % 9), 1'($urandom), 1'h0);
    end
    repeat (2 * converter_clock_period(last_ck)) @(posedge pclk);
    apb(1'h1, OFS_TIMING, 8'h06);
    level <= 10'($urandom);
    apb(1'h1, OFS_CTRL0, 8'h17);
    repeat (300) @(posedge pclk);
    apb(1'h1, OFS_CTRL0, 8'h15);
    apb(1'h0, OFS_FLAG, 8'h00);
    `CHK("abort flag", 8'h00, rd)
    // Abort lands between the fourth and fifth tick: bits 9..7 are converted
    apb(1'h0, OFS_RES_HI, 8'h00);
    `CHK("partial high", {level[9:7], {5{level[7]}}}, rd)
    apb(1'h0, OFS_RES_LO, 8'h00);
    `CHK("partial fill", {2{level[7]}}, rd[7:6])
    report_and_stop();
  end
endmodule // testbench
